// ### sync_relay_pkg.sv
// What this block does
// - sample the command line once every master clock cycle, one bit each.
// - line is idle after more than four consecutive ones.
// - frame starts from idle with one zero, then four bits LSB first.
// - a single one stop bit closes the frame; decoder then waits for line idle again.
// - incoming line is phase aligned to local clock before decoding.
// - one decoded command is re-encoded and sent to all eight transmitters.
// - received commands are decoded further to drive local functions.
// - relay drives the third transmit lane of each fiber; matching receive unused.
package sync_relay_pkg;
  localparam int CMD_BITS        = 4;
  localparam int IDLE_ONES       = 4;
  localparam int FIBER_COUNT     = 8;
  localparam int LANE_COUNT      = 4;
  localparam int SYNC_LANE       = 2;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int BIT_TIME_NS     = 4;
  localparam int BIT_CYCLES      = (BIT_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] RELAY_CMD_RESET = 4'h1;
  localparam logic [2:0] IDLE_CNT_RESET  = 3'h0;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_DATA  = 2'b11,
    ST_STOP  = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic       valid;
    logic       framing_error;
    logic [3:0] command;
  } sync_cmd_t;
endpackage

// ### sync_encoder.sv
`timescale 1ns/1ps
module sync_encoder (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       send_in,
  input  wire logic [3:0] command_in,
  output logic            busy_out,
  output logic            line_out
);
  // **********
  // serial frame shifter
  // **********
  logic [5:0] shift;
  logic [2:0] left;
  logic [2:0] gap;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      shift <= 6'h3F;
      left  <= 3'h0;
      gap   <= 3'h5;
    end else if (left != 3'h0) begin
      shift <= {1'b1, shift[5:1]};
      left  <= left - 3'h1;
      gap   <= 3'h5;
    end else if (gap != 3'h0) begin
      gap   <= gap - 3'h1;
    end else if (send_in) begin
      // start, four bits lsb first, stop
      shift <= {1'b1, command_in, 1'b0};
      left  <= 3'h6;
    end
  end

  // idle gap keeps more than four ones between frames
  assign busy_out = (left != 3'h0) || (gap != 3'h0);
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      line_out <= 1'b1;
    end else begin
      line_out <= (left != 3'h0) ? shift[0] : 1'b1;
    end
  end
endmodule

// ### fixed_latency_sync_relay.sv
`timescale 1ns/1ps
module fixed_latency_sync_relay #(
  parameter int FIBERS = sync_relay_pkg::FIBER_COUNT
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic                    sync_line_in,
  input  wire logic [3:0]              relay_cmd_in,
  input  wire logic [FIBERS-1:0]       sync_rx_lane_in,
  output sync_relay_pkg::sync_cmd_t    cmd_out,
  output logic [15:0]                  local_decode_out,
  output logic                         line_idle_out,
  output logic [FIBERS-1:0]            fiber_sync_tx_out,
  output logic [FIBERS*4-1:0]          fiber_lane_tx_out,
  output logic                         relay_overrun_out
);
  // **********
  // elaboration check
  // **********
  if (FIBERS < 1 || FIBERS > 16) begin : g_bad_fibers
    $error("FIBERS out of range");
  end

  // **********
  // phase alignment of incoming line
  // **********
  logic [2:0] sync_pipe;
  logic       line;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync_pipe <= 3'h7;
      line      <= 1'b1;
    end else begin
      sync_pipe <= {sync_pipe[1:0], sync_line_in};
      // one sample per symbol, so no agreement filter
      line      <= sync_pipe[2];
    end
  end

  // **********
  // idle detection
  // **********
  logic [2:0] ones_cnt;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ones_cnt <= sync_relay_pkg::IDLE_CNT_RESET;
    end else if (!line) begin
      ones_cnt <= 3'h0;
    end else if (ones_cnt <= 3'(sync_relay_pkg::IDLE_ONES)) begin
      ones_cnt <= ones_cnt + 3'h1;
    end
  end
  logic idle_now;
  assign idle_now      = ones_cnt > 3'(sync_relay_pkg::IDLE_ONES);
  assign line_idle_out = idle_now;

  // **********
  // frame decoder
  // **********
  sync_relay_pkg::rx_state_t state;
  logic [1:0] bit_cnt;
  logic [3:0] data;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= sync_relay_pkg::ST_WAIT;
    end else begin
      case (state)
        sync_relay_pkg::ST_WAIT: begin
          if (idle_now) begin
            state <= sync_relay_pkg::ST_IDLE;
          end
        end
        sync_relay_pkg::ST_IDLE: begin
          if (!line) begin
            state <= sync_relay_pkg::ST_DATA;
          end
        end
        sync_relay_pkg::ST_DATA: begin
          if (bit_cnt == 2'h3) begin
            state <= sync_relay_pkg::ST_STOP;
          end
        end
        sync_relay_pkg::ST_STOP: begin
          state <= sync_relay_pkg::ST_WAIT;
        end
        default: begin
          state <= sync_relay_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // data bit counter, cleared outside the data phase
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bit_cnt <= 2'h0;
    end else if (state == sync_relay_pkg::ST_DATA) begin
      bit_cnt <= bit_cnt + 2'h1;
    end else begin
      bit_cnt <= 2'h0;
    end
  end

  // lsb first, so shift in from the top
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      data <= 4'h0;
    end else if (state == sync_relay_pkg::ST_DATA) begin
      data <= {line, data[3:1]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cmd_out <= '0;
    end else begin
      cmd_out.valid         <= (state == sync_relay_pkg::ST_STOP) && line;
      cmd_out.framing_error <= (state == sync_relay_pkg::ST_STOP) && !line;
      if (state == sync_relay_pkg::ST_STOP) begin
        cmd_out.command <= data;
      end
    end
  end

  // **********
  // local one-hot decode
  // **********
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      local_decode_out <= 16'h0000;
    end else begin
      local_decode_out <= 16'h0000;
      if ((state == sync_relay_pkg::ST_STOP) && line) begin
        local_decode_out[data] <= 1'b1;
      end
    end
  end

  // **********
  // relay re-encoding
  // **********
  logic relay_send;
  logic enc_busy;
  logic enc_line;
  assign relay_send = cmd_out.valid && (cmd_out.command == relay_cmd_in);
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      relay_overrun_out <= 1'b0;
    end else begin
      relay_overrun_out <= relay_send && enc_busy;
    end
  end

  sync_encoder u_encoder (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .send_in    (relay_send),
    .command_in (cmd_out.command),
    .busy_out   (enc_busy),
    .line_out   (enc_line)
  );

  // **********
  // fiber fan-out, sync on third lane
  // **********
  always_comb begin
    fiber_lane_tx_out = '0;
    for (int f = 0; f < FIBERS; f++) begin
      fiber_sync_tx_out[f] = enc_line;
      fiber_lane_tx_out[f*4 + sync_relay_pkg::SYNC_LANE] = enc_line;
    end
  end
  // returning sync lanes are ignored by design
  logic unused_rx;
  assign unused_rx = ^sync_rx_lane_in;
endmodule

// ### sync_supervisor_model.sv
`timescale 1ns/1ps
// ***********
// line sender
// ***********
module sync_supervisor_model (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  task automatic send(input logic [3:0] cmd, input logic stop, input int gap);
    logic [5:0] f;
    f = {stop, cmd, 1'b0};
    for (int i = 0; i < 6 + gap; i++) begin
      @(negedge clk_in);
      line_out = (i < 6) ? f[i] : 1'b1;
    end
  endtask
endmodule

// ### sync_relay_checker.sv
`timescale 1ns/1ps
// **********
// assertions
// **********
module sync_relay_checker #(
  parameter int FIBERS = sync_relay_pkg::FIBER_COUNT
) (
  input wire logic                      clk_in,
  input wire logic                      rst_b_in,
  input wire logic                      sync_line_in,
  input wire logic [3:0]                relay_cmd_in,
  input wire sync_relay_pkg::sync_cmd_t cmd_out,
  input wire logic [15:0]               local_decode_out,
  input wire logic                      line_idle_out,
  input wire logic [FIBERS-1:0]         fiber_sync_tx_out,
  input wire logic [FIBERS*4-1:0]       fiber_lane_tx_out,
  input wire logic                      relay_overrun_out
);
  logic [FIBERS*4-1:0] lane_exp;
  logic                tx0;
  logic [2:0]          tx_ones;
  logic                tx_start;
  assign tx0 = fiber_sync_tx_out[0];
  // frame start is a zero after an idle run, not a fall inside data
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_ones <= 3'h0;
    end else if (!tx0) begin
      tx_ones <= 3'h0;
    end else if (tx_ones != 3'h7) begin
      tx_ones <= tx_ones + 3'h1;
    end
  end
  assign tx_start = !tx0 && (tx_ones >= 3'h5);
  always_comb begin
    lane_exp = '0;
    for (int i = 0; i < FIBERS; i++) begin
      lane_exp[4*i+2] = fiber_sync_tx_out[i];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_lane_map: assert property (fiber_lane_tx_out == lane_exp)
    else $error("lane map wrong");
  a_fan_equal: assert property (&fiber_sync_tx_out || ~|fiber_sync_tx_out)
    else $error("fibers differ");
  a_decode_hot: assert property (cmd_out.valid |-> ##[0:1] local_decode_out == 16'h1 << cmd_out.command)
    else $error("local decode wrong");
  a_idle_drop: assert property (!sync_line_in |-> ##[1:6] !line_idle_out)
    else $error("idle kept after zero");
  a_idle_rise: assert property (sync_line_in [*8] ##1 sync_line_in [*4] |-> line_idle_out)
    else $error("idle not seen");
  a_tx_frame: assert property (tx_start |-> ##5 tx0 [*6])
    else $error("relay frame shape wrong");
  a_relay_go: assert property (cmd_out.valid && cmd_out.command == relay_cmd_in |-> ##[0:2] (!tx0 || relay_overrun_out))
    else $error("relay not sent");
  a_relay_cause: assert property (tx_start |-> $past(cmd_out.valid) || $past(cmd_out.valid, 2))
    else $error("relay without command");
  c_valid: cover property (cmd_out.valid);
  c_error: cover property (cmd_out.framing_error);
  c_relay: cover property (tx_start);
  c_overrun: cover property (relay_overrun_out);
endmodule
bind fixed_latency_sync_relay sync_relay_checker #(.FIBERS(FIBERS)) i_sync_relay_checker (
  .clk_in, .rst_b_in, .sync_line_in, .relay_cmd_in, .cmd_out, .local_decode_out,
  .line_idle_out, .fiber_sync_tx_out, .fiber_lane_tx_out, .relay_overrun_out);

// ### fixed_latency_sync_relay_test.sv
`timescale 1ns/1ps
// *****
// bench
// *****
module fixed_latency_sync_relay_test;
  logic                      clk_in;
  logic                      rst_b_in;
  logic                      sync_line_in;
  logic [3:0]                relay_cmd_in;
  sync_relay_pkg::sync_cmd_t cmd_out;
  logic [15:0]               local_decode_out;
  logic [15:0]               dec;
  logic [7:0]                tx;
  logic [6:0]                txh = '1;
  logic [4:0]                tx_cmd;
  logic [3:0]                got;
  logic                      idle;
  logic [31:0]               lanes;
  logic                      ovr;
  int                        n_o;
  int                        bad_count = 0;
  int                        total_checks = 0;
  int                        n_v, n_e, n_t, skip;
  fixed_latency_sync_relay i_fixed_latency_sync_relay (
    .clk_in, .rst_b_in, .sync_line_in, .relay_cmd_in, .sync_rx_lane_in('0),
    .cmd_out, .local_decode_out, .line_idle_out(idle), .fiber_sync_tx_out(tx),
    .fiber_lane_tx_out(lanes), .relay_overrun_out(ovr));
  sync_supervisor_model i_sync_supervisor_model (.clk_in, .line_out(sync_line_in));
  initial begin
    clk_in = 0;
    forever #20 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    txh = {tx[0], txh[6:1]};
    if (cmd_out.valid === 1'b1) begin
      n_v++;
      got = cmd_out.command;
    end
    if (cmd_out.framing_error === 1'b1) n_e++;
    if (ovr === 1'b1) n_o++;
    dec |= local_decode_out;
    if (skip > 0) skip--;
    else if (txh[1:0] === 2'b01) begin
      n_t++;
      tx_cmd = txh[6:2];
      skip = 5;
    end
  end
  task automatic chk_n(input int g, input int e);
    total_checks++;
    if (g != e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic frame(input logic [3:0] c, input logic s, input int gap);
    @(posedge clk_in);
    n_v = 0;
    n_e = 0;
    n_t = 0;
    n_o = 0;
    dec = '0;
    i_sync_supervisor_model.send(c, s, gap);
  endtask
  task automatic t_each_cmd();
    for (int c = 0; c < 16; c++) begin
      frame(4'(c), 1'b1, 6);
      repeat (12) @(negedge clk_in);
      chk_n(n_v, 1);
      chk_v(16'(got), 16'(c));
      chk_v(dec, 16'h1 << c);
      chk_n(n_t, int'(c == 10));
    end
    chk_v(16'(tx_cmd), 16'h1A);
  endtask
  task automatic t_bad_stop();
    frame(4'h3, 1'b0, 6);
    repeat (12) @(negedge clk_in);
    chk_n(n_e, 1);
    chk_n(n_v, 0);
  endtask
  task automatic t_short_gap();
    frame(4'h5, 1'b1, 2);
    i_sync_supervisor_model.send(4'h6, 1'b1, 6);
    repeat (12) @(negedge clk_in);
    chk_n(n_v, 1);
    chk_v(16'(got), 16'h5);
  endtask
  task automatic t_overrun();
    frame(4'hA, 1'b1, 4);
    i_sync_supervisor_model.send(4'hA, 1'b1, 6);
    repeat (16) @(negedge clk_in);
    chk_n(n_v, 2);
    chk_n(n_t, 1);
    chk_n(n_o, 1);
    chk_v(16'(idle), 16'h1);
    chk_v(lanes[15:0], 16'h4444);
    chk_v(lanes[31:16], 16'h4444);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_b_in = 0;
    relay_cmd_in = 4'hA;
    skip = 0;
    repeat (12) @(negedge clk_in);
    rst_b_in = 1;
    repeat (8) @(negedge clk_in);
    t_each_cmd();
    t_bad_stop();
    t_short_gap();
    t_overrun();
    results();
  end
  initial begin
    repeat (2000) @(posedge clk_in);
    bad_count++;
    results();
  end
endmodule
